// [core/mtx_pkg.sv]
// Constants for the modem transmit front end: clock rate, bit and carrier
// timing, character length codes and the phase step table.
// Assumes a single 125 MHz master clock drives the whole block.
package mtx_pkg;
  // Master clock and line rates
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BIT_HZ = 1200;
  localparam int unsigned CAR_LO_HZ = 1200;
  localparam int unsigned CAR_HI_HZ = 2400;
  // Bit period and quarter periods of the carrier, rounded to nearest for best accuracy
  localparam int unsigned BIT_CYC_NOM = (CLK_HZ + BIT_HZ / 2) / BIT_HZ;
  localparam int unsigned CARQ_LO_NOM = (CLK_HZ + 2 * CAR_LO_HZ) / (4 * CAR_LO_HZ);
  localparam int unsigned CARQ_HI_NOM = (CLK_HZ + 2 * CAR_HI_HZ) / (4 * CAR_HI_HZ);
  // Character length code: total bits = 8 + code
  localparam logic [1:0] LEN_8 = 2'h0;
  localparam logic [1:0] LEN_11 = 2'h3;
  localparam int unsigned LEN_BASE = 8;
  // Scrambler taps and length
  localparam int unsigned SCR_LEN = 17;
  localparam int unsigned TAP_A = 14;
  localparam int unsigned TAP_B = 17;
  // Largest number of data bits in a character
  localparam int unsigned DATA_MAX = 9;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_BITS = 2'h3
  } mtx_rx_t;

  // Quarter-turn step of the carrier for each dibit
  function automatic logic [1:0] mtx_step(input logic [1:0] sym);
    case (sym)
      2'h0: mtx_step = 2'h1;
      2'h1: mtx_step = 2'h0;
      2'h3: mtx_step = 2'h3;
      2'h2: mtx_step = 2'h2;
      default: mtx_step = 2'h0;
    endcase
  endfunction
endpackage

// [core/mtx_tx_front.sv]
// Transmit front end: async-to-sync re-timing, 17-stage scrambler,
// dibit former and differential phase carrier with speed select.
// Assumes txData and all mode inputs are synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Characters are sampled mid-bit on the nominal bit time, tolerating -2.5% to +1%.
// - Output bits leave at 1200 Hz from a divider of the master clock, not of the input.
// - When no character waits, an extra stop bit is sent to keep output continuous.
// - When a character waits as the stop bit is due, that stop bit is dropped.
// - Characters of 8 to 11 total bits are handled, and a synchronous mode exists.
// - The re-timed bit stream is the scrambler input.
// - The scrambler is a 17-stage register advancing once per bit tick.
// - Stages 14 and 17 are XORed and then XORed with the input bit.
// - Each scrambled bit shifts into the first stage.
// - Stages one and two together form the dibit sent to the phase modulator.
// - A dibit is taken after every second bit tick, giving 600 baud.
// - Each dibit steps the carrier phase by one of four quarter turns at 1200 or 2400 Hz.
// - The phase carrier goes out in high speed, the frequency-shift input in low speed.
module mtx_tx_front
  import mtx_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_NOM,
  parameter int unsigned CARQ_LO = CARQ_LO_NOM,
  parameter int unsigned CARQ_HI = CARQ_HI_NOM
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic txData,
  input wire logic syncMode,
  input wire logic [1:0] charLen,
  input wire logic lowSpeed,
  input wire logic highBand,
  input wire logic fskIn,
  output logic bitTick,
  output logic symbolTick,
  output logic scrData,
  output logic [1:0] dibit,
  output logic carrier,
  output logic modOut
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam int QW = $clog2(CARQ_LO + CARQ_HI + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYC / 2 - 1);

  logic [CW-1:0] bitCnt;
  logic bitStb;
  logic half;
  logic symGo;
  logic [SCR_LEN-1:0] scr;
  logic inBit;
  logic scrBit;
  mtx_rx_t rxState;
  logic [CW-1:0] rxCnt;
  logic [3:0] rxIdx;
  logic [DATA_MAX-1:0] rxShift;
  logic [DATA_MAX-1:0] holdData;
  logic holdFull;
  logic rxDone;
  logic [DATA_MAX:0] outShift;
  logic [3:0] outLeft;
  logic loadOut;
  logic [3:0] dataBits;
  logic [QW-1:0] carCnt;
  logic [1:0] carQ;
  logic qTick;

  assign dataBits = 4'(LEN_BASE - 2) + {2'h0, charLen};

  // Output bit clock from the master oscillator
  // fixed bit divider
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt <= '0;
      bitStb <= 1'b0;
    end else if (clkEn) begin
      bitStb <= (bitCnt == BIT_LAST);
      bitCnt <= (bitCnt == BIT_LAST) ? '0 : bitCnt + 1'b1;
    end
  end

  // Character receiver sampling mid-bit
  // nominal mid-bit sampling
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxState <= RX_IDLE;
      rxCnt <= '0;
      rxIdx <= 4'h0;
      rxShift <= '0;
      rxDone <= 1'b0;
    end else if (clkEn) begin
      rxDone <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          rxCnt <= '0;
          if (!syncMode && !txData) begin
            rxState <= RX_START;
          end
        end
        RX_START: begin
          rxCnt <= rxCnt + 1'b1;
          if (rxCnt == BIT_HALF) begin
            rxCnt <= '0;
            rxIdx <= 4'h0;
            rxState <= txData ? RX_IDLE : RX_BITS; // Glitch rejects
          end
        end
        RX_BITS: begin
          rxCnt <= rxCnt + 1'b1;
          if (rxCnt == BIT_LAST) begin
            rxCnt <= '0;
            rxIdx <= rxIdx + 1'b1;
            if (rxIdx == dataBits) begin
              rxDone <= 1'b1; // Stop bit slot reached
              rxState <= RX_IDLE;
            end else begin
              rxShift[rxIdx] <= txData;
            end
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Holding register between the two rates
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdData <= '0;
      holdFull <= 1'b0;
    end else if (clkEn) begin
      if (rxDone) begin
        holdData <= rxShift;
        holdFull <= 1'b1; // Set wins over load
      end else if (loadOut) begin
        holdFull <= 1'b0;
      end
    end
  end

  // Next output bit of the re-timed stream
  always_comb begin
    loadOut = 1'b0;
    inBit = 1'b1;
    if (syncMode) begin
      inBit = txData;
    end else if (outLeft > 4'h1) begin
      inBit = outShift[0];
    end else if (holdFull) begin
      loadOut = bitStb;
      inBit = 1'b0;
    end else if (outLeft == 4'h1) begin
      inBit = outShift[0];
    end else begin
      inBit = 1'b1;
    end
  end

  // Output framer: start, data, stop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      outShift <= '1;
      outLeft <= 4'h0;
    end else if (clkEn && bitStb) begin
      if (syncMode) begin
        outLeft <= 4'h0;
      end else if (loadOut) begin
        outShift <= {1'b1, holdData} | ({(DATA_MAX + 1){1'b1}} << dataBits);
        outLeft <= dataBits + 4'h1;
      end else if (outLeft != 4'h0) begin
        outShift <= {1'b1, outShift[DATA_MAX:1]};
        outLeft <= outLeft - 4'h1;
      end
    end
  end

  assign scrBit = inBit ^ scr[TAP_A-1] ^ scr[TAP_B-1];

  // Scrambler register and pair counter
  // shift per bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scr <= '0;
      scrData <= 1'b0;
      bitTick <= 1'b0;
      half <= 1'b0;
      symGo <= 1'b0;
    end else if (clkEn) begin
      bitTick <= bitStb;
      symGo <= bitStb && half;
      if (bitStb) begin
        scr <= {scr[SCR_LEN-2:0], scrBit};
        scrData <= scrBit;
        half <= ~half;
      end
    end
  end

  // Dibit capture at the symbol rate
  // stages one and two
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dibit <= 2'h0;
      symbolTick <= 1'b0;
    end else if (clkEn) begin
      symbolTick <= symGo;
      if (symGo) begin
        dibit <= scr[1:0];
      end
    end
  end

  // Carrier quarter-period divider
  assign qTick = (carCnt == '0);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      carCnt <= '0;
      carQ <= 2'h0;
    end else if (clkEn) begin
      carCnt <= qTick ? QW'((highBand ? CARQ_HI : CARQ_LO) - 1) : carCnt - 1'b1;
      carQ <= carQ + {1'b0, qTick} + (symGo ? mtx_step(scr[1:0]) : 2'h0);
    end
  end

  // Speed select onto the filter path
  // modulator routing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      carrier <= 1'b0;
      modOut <= 1'b0;
    end else if (clkEn) begin
      carrier <= carQ[1];
      modOut <= lowSpeed ? fskIn : carQ[1];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  bit_divider_a: assert property (bitCnt <= BIT_LAST) else $error("bit counter overran");
  scr_feedback_a: assert property (clkEn && bitStb |=> scr[0] == $past(scrBit) && scrData == scr[0]) else $error("scrambler feedback wrong");
  scr_shift_a: assert property (clkEn && bitStb |=> scr[SCR_LEN-1:1] == $past(scr[SCR_LEN-2:0])) else $error("scrambler shift wrong");
  scr_hold_a: assert property (clkEn && !bitStb |=> $stable(scr)) else $error("scrambler moved off tick");
  dibit_take_a: assert property (symbolTick |-> dibit == scr[1:0]) else $error("dibit not from stages");
  symbol_pair_a: assert property (clkEn && bitStb && half ##1 clkEn |=> symbolTick) else $error("symbol not after pair");
  speed_route_a: assert property (clkEn |=> modOut == $past(lowSpeed ? fskIn : carQ[1])) else $error("modulator route wrong");
  sync_bypass_a: assert property (syncMode && bitStb |-> inBit == txData) else $error("sync bypass broken");
  stop_insert_a: assert property (!syncMode && outLeft == 4'h0 && !holdFull |-> inBit) else $error("idle not stop bit");
  stop_delete_a: assert property (!syncMode && outLeft <= 4'h1 && holdFull && bitStb && clkEn |=> outLeft == $past(dataBits) + 4'h1) else $error("stop not dropped");

  // Held character taken by the framer; no long delay range needed
  char_taken_c: cover property (clkEn && holdFull && loadOut);
  stop_drop_c: cover property (bitStb && outLeft == 4'h1 && holdFull);
  symbol_c: cover property (symbolTick && dibit == 2'h3);
endmodule
`default_nettype wire

// [test/mtx_term.sv]
// Terminal model: sends framed characters on the serial data line.
// Assumes it is called on the falling edge of mclk; the line idles high.
`timescale 1ns/10ps
`default_nettype none
module mtx_term (
  input wire logic mclk,
  output logic txData
);
  initial txData = 1'b1;
  // Level for sync mode or idle
  task automatic put(input logic b);
    txData <= b;
  endtask
  task automatic send(input logic [8:0] d, input int nb, input int per);
    int t;
    int c;
    t = 0;
    c = 0;
    for (int i = 0; i < nb + 2; i++) begin
      txData <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1];
      t += per;
      while (c * 100 < t) begin
        @(negedge mclk);
        c++;
      end
    end
  endtask
endmodule
`default_nettype wire

// [test/mtx_tx_front_tb.sv]
// Bench for the transmit front end: scrambler, re-timing, ticks, speed.
// Assumes shortened counts: 40 cycles a bit, carrier quarters of 20 and 10.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); \
    end \
  end
module mtx_tx_front_tb;
  import mtx_pkg::*;
  localparam int unsigned BC = 40;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic enSeen = 1'b1;
  // mode lines set directly in place of the control port
  logic syncMode = 1'b1;
  logic [1:0] charLen = 2'h0;
  logic lowSpeed = 1'b0;
  logic highBand = 1'b0;
  logic fskIn = 1'b0;
  logic txData, bitTick, symbolTick, scrData, carrier, modOut;
  logic [1:0] dibit;
  logic [16:0] hist = 17'h0;
  logic rx[$];
  int miscompares = 0;
  int compares = 0;
  int since = 0;
  int ticks = 0;
  int symAt = -1;
  mtx_tx_front #(.BIT_CYC(BC), .CARQ_LO(20), .CARQ_HI(10)) mtx_tx_front_i (
    .mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .txData(txData),
    .syncMode(syncMode), .charLen(charLen), .lowSpeed(lowSpeed),
    .highBand(highBand), .fskIn(fskIn), .bitTick(bitTick),
    .symbolTick(symbolTick), .scrData(scrData), .dibit(dibit),
    .carrier(carrier), .modOut(modOut));
  mtx_term mtx_term_i (.mclk(mclk), .txData(txData));
  always #4 mclk = ~mclk;
  // Enable as seen by the last rising edge
  always @(posedge mclk) enSeen <= clkEn;
  // Tick spacing, dibit pairing and descrambling of the line
  always @(negedge mclk) begin
    if (enSeen) since++;
    if (arst_n && bitTick === 1'b1) begin
      if (ticks > 0) `CHK("bit period", BC, since)
      ticks++;
      since = 0;
      rx.push_back(scrData ^ hist[13] ^ hist[16]);
      hist = {hist[15:0], scrData};
    end
    if (arst_n && symbolTick === 1'b1) begin
      if (symAt >= 0) `CHK("symbol gap", 2, ticks - symAt)
      `CHK("dibit", hist[1:0], dibit)
      symAt = ticks;
    end
  end
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (bitTick !== 1'b1 && n < 200);
  endtask
  // Known bits straight into the scrambler
  task automatic t_sync();
    logic [16:0] m;
    logic b;
    m = 17'h0;
    for (int i = 0; i < 40; i++) begin
      b = i[0] ^ i[3] ^ (i > 30);
      mtx_term_i.put(b);
      wait_tick();
      `CHK("scr bit", b ^ m[13] ^ m[16], scrData)
      m = {m[15:0], b ^ m[13] ^ m[16]};
    end
  endtask
  // Characters at a given rate, then frame parse
  task automatic t_async(input int per, input int nc, input int len, input int want);
    int p;
    int st;
    int lo;
    int hi;
    logic [8:0] got;
    p = 0;
    lo = 99;
    hi = 0;
    syncMode = 1'b0;
    charLen = len[1:0];
    mtx_term_i.put(1'b1);
    repeat (4) wait_tick();
    rx.delete();
    for (int k = 0; k < nc; k++) mtx_term_i.send(9'(k * 9'h5B + 9'h3C), len + 6, per);
    repeat (25) wait_tick();
    while (p < rx.size() && rx[p]) p++;
    for (int k = 0; k < nc; k++) begin
      got = 9'h0;
      for (int i = 0; i < len + 6; i++) got[i] = rx[p + 1 + i];
      `CHK("data", 9'(k * 9'h5B + 9'h3C) & (9'h1FF >> (3 - len)), got)
      p += len + 7;
      st = 0;
      while (p < rx.size() && rx[p]) begin
        p++;
        st++;
      end
      if (k < nc - 1) lo = (st < lo) ? st : lo;
      if (k < nc - 1) hi = (st > hi) ? st : hi;
    end
    if (want == 1) `CHK("stop dropped", 1'b1, lo == 0)
    if (want == 2) `CHK("stop added", 1'b1, hi > 1)
  endtask
  // Speed select between shift-keyed input and phase carrier
  task automatic t_speed();
    logic c;
    int tg;
    tg = 0;
    lowSpeed = 1'b1;
    for (int i = 0; i < 8; i++) begin
      fskIn = i[0];
      @(negedge mclk);
      `CHK("fsk out", fskIn, modOut)
    end
    lowSpeed = 1'b0;
    highBand = 1'b1;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 200; i++) begin
      c = carrier;
      @(negedge mclk);
      tg += int'(carrier != c);
      `CHK("psk out", carrier, modOut)
    end
    `CHK("carrier runs", 1'b1, tg > 4)
  endtask
  // Clock enable low freezes every output between ticks
  task automatic t_freeze();
    logic [6:0] snap;
    wait_tick();
    repeat (2) @(negedge mclk);
    clkEn = 1'b0;
    snap = {bitTick, symbolTick, scrData, dibit, carrier, modOut};
    repeat (100) begin
      @(negedge mclk);
      `CHK("frozen", snap, {bitTick, symbolTick, scrData, dibit, carrier, modOut})
    end
    clkEn = 1'b1;
  endtask
  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    t_sync();
    t_freeze();
    for (int l = 0; l < 4; l++) t_async(4000, 3, l, 0);
    t_async(3961, 20, 3, 1);
    t_async(4102, 10, 3, 2);
    t_speed();
    results();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
